// *** smc_defines.svh ***
/*
  Constants of the serial communication unit core: mode codes, address
  match kinds, flag positions, field widths and reset values.
  Assumes inclusion by bare name from the package and the core.
*/
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define SMC_MODE_USART_EXT 3'h0
`define SMC_MODE_USART_INT 3'h1
`define SMC_MODE_SPI_SLV 3'h2
`define SMC_MODE_SPI_MST 3'h3
`define SMC_MODE_I2C_SLV 3'h4
`define SMC_MODE_I2C_MST 3'h5

// ----------------------------------------------------------------------
// Address match kinds
// ----------------------------------------------------------------------
`define SMC_AM_MASK 2'h0
`define SMC_AM_TWO 2'h1
`define SMC_AM_RANGE 2'h2

// ----------------------------------------------------------------------
// Flag positions, widths, frame counts and reset values
// ----------------------------------------------------------------------
`define SMC_FL_TXC 0
`define SMC_FL_RXC 1
`define SMC_FL_AMATCH 2
`define SMC_FL_OVF 3
`define SMC_FL_DRE 4
`define SMC_NFLAG 5
`define SMC_FRAME_BITS 4'h9
`define SMC_DATA_LAST 4'h7
`define SMC_RST_BAUD 16'h0000
`define SMC_RST_MODE 3'h0

`endif

// *** smc_pkg.sv ***
/*
  Types of the serial communication unit core: receive state and the
  packed state record of the core.
  Assumes smc_defines.svh is on the include path.
*/
`include "smc_defines.svh"

package smc_pkg;

  // Receive framing state
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} smc_rx_t;

  // Whole state of the core
  typedef struct packed {
    logic enable;
    logic [2:0] mode;
    logic [15:0] baud;
    logic [1:0] txpo;
    logic [1:0] rxpo;
    logic [1:0] amode;
    logic [7:0] addr;
    logic [7:0] amask;
    logic [`SMC_NFLAG-1:0] ien;
    logic [3:0] flags;
    logic dbg_halt_en;
    logic sync_busy;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic [9:0] txsh;
    logic [3:0] txcnt;
    logic txbusy;
    smc_rx_t rxst;
    logic [3:0] rxcnt;
    logic [7:0] rxsh;
    logic [1:0][7:0] rxb;
    logic [1:0] rxn;
    logic [15:0] bcnt;
    logic sck;
    logic [3:0] pad_s1;
    logic [3:0] pad_s2;
    logic [2:0] ext_s;
  } smc_state_t;

endpackage

// *** smc_core.sv ***
/*
  Core of the multi-mode serial communication unit: configuration
  state, single transmit buffer, double receive buffer, baud-rate
  generator, address matching, pad routing, interrupt request.
  Assumes one clock for control and engine; pads and the external
  serial clock arrive asynchronously and are synchronised here.
*/
// Functional notes
// - Enabled unit serves only the chosen mode
// - One transmit buffer ahead of shift register
// - Shift register feeds two-entry receive buffer
// - Serial data and master clock use four pads; external clock has its own input
// - Pad routing chosen by mode configuration
// - Bus clock gate enables register writes
// - Master modes need core clock running
// - Slow clock requested only for two-wire
// - Configuration writes synchronised, busy shown
// - Engine runs on internal or external clock
// - Baud generator sourced internally or externally
// - Address match only in SPI and I2C
// - Keeps running during debug halt by default
// - Option halts unit during debug halt
// - Write protection spares flags, address, data
// - Debug halt lifts write protection
// - Interrupt also serves as wake request
// - Single request line to interrupt controller
// - Three-bit mode field, six codes valid
// - Soft reset sets sync busy, clears all but debug and synchronisers
// - Request while flag and enable set
// - All sources share one request line
`timescale 1ns/10ps
`include "smc_defines.svh"

module smc_core
  import smc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Clock and power control
  input wire logic bus_clk_en_i,
  input wire logic core_clk_en_i,
  input wire logic ext_clk_i,
  // Debug and protection
  input wire logic cpu_halt_i,
  input wire logic wp_i,
  input wire logic dbg_we_i,
  input wire logic dbg_halt_en_i,
  // Control writes
  input wire logic soft_reset_i,
  input wire logic cfg_we_i,
  input wire logic cfg_enable_i,
  input wire logic [2:0] cfg_mode_i,
  input wire logic [15:0] cfg_baud_i,
  input wire logic [1:0] cfg_txpo_i,
  input wire logic [1:0] cfg_rxpo_i,
  input wire logic [1:0] cfg_amode_i,
  input wire logic [`SMC_NFLAG-1:0] ien_set_i,
  input wire logic [`SMC_NFLAG-1:0] ien_clr_i,
  input wire logic [3:0] flag_clr_i,
  // Address writes
  input wire logic addr_we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] amask_i,
  // Transmit data
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // Receive data
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  input wire logic rx_read_i,
  // Pads
  input wire logic [3:0] pad_i,
  output logic [3:0] pad_o,
  output logic [3:0] pad_oe_o,
  // Status
  output logic enabled_o,
  output logic [2:0] mode_o,
  output logic [`SMC_NFLAG-1:0] flags_o,
  output logic [`SMC_NFLAG-1:0] ien_o,
  output logic dbg_halt_en_o,
  output logic sync_busy_o,
  output logic slow_req_o,
  output logic irq_o,
  output logic wake_o
);

  smc_state_t s;
  smc_state_t next_s;

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  logic valid_mode;
  logic master;
  logic use_ext;
  logic halted;
  logic run;
  logic wr_ok;
  logic prot_ok;
  logic tick;
  logic rx_bit;
  logic [`SMC_NFLAG-1:0] flags_all;

  // Protected writes need the bus clock and no active protection
  assign valid_mode = s.mode <= `SMC_MODE_I2C_MST;
  assign master = (s.mode == `SMC_MODE_SPI_MST) ||
                  (s.mode == `SMC_MODE_I2C_MST) ||
                  (s.mode == `SMC_MODE_USART_INT);
  assign use_ext = !master;
  assign halted = cpu_halt_i && s.dbg_halt_en;
  // Master modes stall while the core clock is stopped
  assign run = s.enable && valid_mode && !halted &&
               (!master || core_clk_en_i);
  assign wr_ok = bus_clk_en_i;
  assign prot_ok = wr_ok && (!wp_i || cpu_halt_i);
  // External edge uses the second and third stages only
  assign tick = run && (use_ext ? (s.ext_s[1] && !s.ext_s[2])
                                : (s.bcnt == s.baud));
  assign rx_bit = s.pad_s2[s.rxpo];
  assign flags_all = {s.enable && !s.txbuf_full, s.flags};

  // Address comparison on a received word
  function automatic logic amatch(input logic [7:0] w,
                                  input logic [1:0] kind,
                                  input logic [7:0] a,
                                  input logic [7:0] m);
    logic r;
    r = 1'b0;
    case (kind)
      `SMC_AM_MASK: r = ((w ^ a) & ~m) == 8'h00;
      `SMC_AM_TWO: r = (w == a) || (w == m);
      `SMC_AM_RANGE: r = (w <= a) && (w >= m);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic push;
    logic pop;
    logic [3:0] fset;
    push = 1'b0;
    fset = 4'h0;
    next_s = s;
    pop = rx_read_i && s.rxn != 2'h0;
    next_s.sync_busy = 1'b0;
    // Pin synchronisers; first stage feeds only the second
    next_s.pad_s1 = pad_i;
    next_s.pad_s2 = s.pad_s1;
    next_s.ext_s = {s.ext_s[1:0], ext_clk_i};
    // Internal baud divider, period baud plus one
    if (!run || use_ext || s.bcnt == s.baud)
    begin
      next_s.bcnt = 16'h0000;
    end
    else
    begin
      next_s.bcnt = s.bcnt + 16'h0001;
    end
    next_s.sck = run && master && (s.bcnt > {1'b0, s.baud[15:1]});
    // Transmit: buffer loads shift register when it is idle
    if (tick && s.txbusy)
    begin
      next_s.txsh = {1'b1, s.txsh[9:1]};
      next_s.txcnt = s.txcnt + 4'h1;
      if (s.txcnt == `SMC_FRAME_BITS)
      begin
        next_s.txbusy = 1'b0;
        fset[`SMC_FL_TXC] = 1'b1;
      end
    end
    if (run && !next_s.txbusy && s.txbuf_full)
    begin
      next_s.txsh = {1'b1, s.txbuf, 1'b0};
      next_s.txcnt = 4'h0;
      next_s.txbusy = 1'b1;
      next_s.txbuf_full = 1'b0;
    end
    // Data writes are never protected
    if (tx_valid_i && wr_ok && !s.txbuf_full)
    begin
      next_s.txbuf = tx_data_i;
      next_s.txbuf_full = 1'b1;
    end
    // Receive framing: start bit, eight data bits, stop bit
    if (tick)
    begin
      case (s.rxst)
        RX_IDLE:
        begin
          if (!rx_bit)
          begin
            next_s.rxst = RX_DATA;
            next_s.rxcnt = 4'h0;
          end
        end
        RX_DATA:
        begin
          next_s.rxsh = {rx_bit, s.rxsh[7:1]};
          next_s.rxcnt = s.rxcnt + 4'h1;
          if (s.rxcnt == `SMC_DATA_LAST)
          begin
            next_s.rxst = RX_STOP;
          end
        end
        RX_STOP:
        begin
          next_s.rxst = RX_IDLE;
          push = 1'b1;
        end
        default: next_s.rxst = RX_IDLE;
      endcase
    end
    // Two-entry receive buffer; a full buffer drops and flags
    if (pop)
    begin
      next_s.rxb[0] = s.rxb[1];
      next_s.rxn = s.rxn - 2'h1;
    end
    if (push)
    begin
      if (s.rxn == 2'h2 && !pop)
      begin
        fset[`SMC_FL_OVF] = 1'b1;
      end
      else
      begin
        next_s.rxb[pop ? s.rxn - 2'h1 : s.rxn] = s.rxsh;
        next_s.rxn = next_s.rxn + 2'h1;
        fset[`SMC_FL_RXC] = 1'b1;
        if (s.mode >= `SMC_MODE_SPI_SLV &&
            amatch(s.rxsh, s.amode, s.addr, s.amask))
        begin
          fset[`SMC_FL_AMATCH] = 1'b1;
        end
      end
    end
    // Flags: clearing is unprotected and a new set wins
    if (wr_ok)
    begin
      next_s.flags = s.flags & ~flag_clr_i;
    end
    next_s.flags = next_s.flags | fset;
    if (addr_we_i && wr_ok)
    begin
      next_s.addr = addr_i;
      next_s.amask = amask_i;
    end
    if (prot_ok)
    begin
      next_s.ien = (s.ien | ien_set_i) & ~ien_clr_i;
    end
    // Mode and routing are locked while enabled
    if (cfg_we_i && prot_ok)
    begin
      next_s.enable = cfg_enable_i;
      next_s.sync_busy = 1'b1;
      if (!s.enable)
      begin
        next_s.mode = cfg_mode_i;
        next_s.baud = cfg_baud_i;
        next_s.txpo = cfg_txpo_i;
        next_s.rxpo = cfg_rxpo_i;
        next_s.amode = cfg_amode_i;
      end
    end
    // Leaving enable drops any frame in progress
    if (!next_s.enable)
    begin
      next_s.txbusy = 1'b0;
      next_s.rxst = RX_IDLE;
    end
    if (dbg_we_i && prot_ok)
    begin
      next_s.dbg_halt_en = dbg_halt_en_i;
    end
    // Soft reset sets sync busy and clears all but debug control and synchronisers;
    // it lives in the protected control register
    if (soft_reset_i && prot_ok)
    begin
      next_s = '0;
      next_s.mode = `SMC_RST_MODE;
      next_s.baud = `SMC_RST_BAUD;
      next_s.rxst = RX_IDLE;
      next_s.sync_busy = 1'b1;
      next_s.dbg_halt_en = s.dbg_halt_en;
      next_s.pad_s1 = pad_i;
      next_s.pad_s2 = s.pad_s1;
      next_s.ext_s = {s.ext_s[1:0], ext_clk_i};
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Pad routing
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pad
      logic is_tx;
      logic is_sck;
      logic tx_bit;
      assign is_tx = s.enable && valid_mode && s.txpo == gi;
      assign is_sck = s.enable && master && s.mode != `SMC_MODE_USART_INT
                      && s.txpo + 2'h1 == gi;
      assign tx_bit = !s.txbusy || s.txsh[0];
      // Two-wire transmit pad is open drain: drive only the low level
      always_comb
      begin
        if (is_tx && s.mode >= `SMC_MODE_I2C_SLV)
        begin
          pad_o[gi] = 1'b0;
          pad_oe_o[gi] = !tx_bit;
        end
        else if (is_tx)
        begin
          pad_o[gi] = tx_bit;
          pad_oe_o[gi] = 1'b1;
        end
        else if (is_sck)
        begin
          pad_o[gi] = s.sck;
          pad_oe_o[gi] = 1'b1;
        end
        else
        begin
          pad_o[gi] = 1'b0;
          pad_oe_o[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign tx_ready_o = wr_ok && !s.txbuf_full;
  assign rx_valid_o = s.rxn != 2'h0;
  assign rx_data_o = s.rxb[0];
  assign enabled_o = s.enable;
  assign mode_o = s.mode;
  assign flags_o = flags_all;
  assign ien_o = s.ien;
  assign dbg_halt_en_o = s.dbg_halt_en;
  assign sync_busy_o = s.sync_busy;
  assign slow_req_o = s.enable && s.mode >= `SMC_MODE_I2C_SLV &&
                      valid_mode;
  // One shared line for every source
  assign irq_o = |(flags_all & s.ien);
  assign wake_o = irq_o;

endmodule

// *** smc_core_checker.sv ***
/* Port checker of smc_core.
   Assumes a bind to smc_core, one clock, synchronous reset rst_i. */
`timescale 1ns/10ps
`include "smc_defines.svh"
module smc_core_checker
(
  // Clock, reset and controls
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bus_clk_en_i,
  input wire logic cpu_halt_i,
  input wire logic wp_i,
  input wire logic dbg_we_i,
  input wire logic soft_reset_i,
  input wire logic cfg_we_i,
  input wire logic cfg_enable_i,
  input wire logic tx_valid_i,
  // Watched outputs
  input wire logic tx_ready_o,
  input wire logic [3:0] pad_oe_o,
  input wire logic enabled_o,
  input wire logic [2:0] mode_o,
  input wire logic [`SMC_NFLAG-1:0] flags_o,
  input wire logic [`SMC_NFLAG-1:0] ien_o,
  input wire logic dbg_halt_en_o,
  input wire logic sync_busy_o,
  input wire logic slow_req_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // Write that passes protection; soft reset kept apart
  sequence wr_ok;
    bus_clk_en_i && (!wp_i || cpu_halt_i) && !soft_reset_i;
  endsequence
  // Halted unit holding a waiting word
  sequence frozen;
    enabled_o && cpu_halt_i && dbg_halt_en_o && !tx_ready_o && bus_clk_en_i;
  endsequence

  // Request, wake, write, buffer and mode relations
  irq_or_a: assert property (irq_o == |(flags_o & ien_o))
    else $error("irq not the or of enabled flags");
  wake_eq_a: assert property (wake_o == irq_o)
    else $error("wake differs from irq");
  cfg_take_a: assert property (wr_ok ##0 cfg_we_i |=> enabled_o == $past(cfg_enable_i))
    else $error("config write not taken");
  cfg_prot_a: assert property (cfg_we_i && wp_i && !cpu_halt_i && !soft_reset_i
    |=> $stable(enabled_o))
    else $error("protected write took effect");
  sync_busy_a: assert property (wr_ok ##0 cfg_we_i |=> sync_busy_o)
    else $error("no busy after config write");
  soft_clr_a: assert property (soft_reset_i && bus_clk_en_i && !dbg_we_i
    && (!wp_i || cpu_halt_i) |=> !enabled_o && ien_o == 5'h00
    && flags_o == 5'h00 && $stable(dbg_halt_en_o))
    else $error("soft reset result wrong");
  mode_lock_a: assert property (enabled_o && cfg_we_i && !soft_reset_i
    |=> mode_o == $past(mode_o))
    else $error("mode changed while enabled");
  tx_take_a: assert property (tx_valid_i && tx_ready_o && !soft_reset_i
    && !cfg_we_i |=> !tx_ready_o)
    else $error("buffer not full after write");
  bus_gate_a: assert property (tx_ready_o |-> bus_clk_en_i)
    else $error("ready without bus clock");
  halt_hold_a: assert property (frozen ##0 !soft_reset_i && !cfg_we_i
    |=> !tx_ready_o)
    else $error("buffer drained during halt");
  slow_req_a: assert property (slow_req_o
    == (enabled_o && (mode_o == 3'h4 || mode_o == 3'h5)))
    else $error("slow request wrong");
  resv_idle_a: assert property (enabled_o && mode_o[2:1] == 2'b11
    |-> pad_oe_o == 4'h0)
    else $error("pads driven in reserved mode");
endmodule

bind smc_core smc_core_checker u_chk (
  .ref_clk_i, .rst_i, .bus_clk_en_i, .cpu_halt_i, .wp_i, .dbg_we_i,
  .soft_reset_i, .cfg_we_i, .cfg_enable_i, .tx_valid_i, .tx_ready_o,
  .pad_oe_o, .enabled_o, .mode_o, .flags_o, .ien_o, .dbg_halt_en_o,
  .sync_busy_o, .slow_req_o, .irq_o, .wake_o
);

// *** smc_uart_peer.sv ***
/* Serial peer on the pads: sends and receives 10-bit frames.
   Assumes bit time equals the core's tick period in clock cycles. */
`timescale 1ns/10ps
module smc_uart_peer #(parameter int BIT_CYC = 4)
(
  // Clock
  input wire logic ref_clk_i,
  // Serial lines
  input wire logic line_i,
  output logic line_o,
  // Bench control and result
  input wire logic send_i,
  input wire logic [7:0] data_i,
  output logic [7:0] got_o,
  output logic [7:0] cnt_o
);
  initial line_o = 1'b1;
  initial cnt_o = 8'h00;
  initial got_o = 8'h00;

  // Start low, data LSB first, stop high; idle high between frames
  always @(posedge ref_clk_i)
  begin
    if (send_i)
    begin
      for (int i = 0; i < 10; i++)
      begin
        line_o <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : data_i[i-1];
        repeat (BIT_CYC) @(posedge ref_clk_i);
      end
    end
  end

  // The free-running divider may cut the start bit to one cycle, so
  // each bit is read in the one cycle it covers whatever that length;
  // counts only frames with a good stop
  always @(negedge line_i)
  begin
    @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge ref_clk_i);
      got_o[i] <= line_i;
    end
    repeat (BIT_CYC) @(posedge ref_clk_i);
    if (line_i)
      cnt_o <= cnt_o + 8'h01;
  end
endmodule

// *** multi_mode_serial_engine_core_bench.sv ***
/* Directed bench of smc_core with a serial peer on pads 0 and 2.
   Assumes the checker and the peer are compiled before it. */
`timescale 1ns/10ps
module multi_mode_serial_engine_core_bench;
  logic ref_clk_i, rst_i, bus_clk_en_i, core_clk_en_i, cpu_halt_i, wp_i;
  logic dbg_we_i, dbg_halt_en_i, soft_reset_i, cfg_we_i, cfg_enable_i;
  logic addr_we_i, tx_valid_i, rx_read_i, p_send, tx_line, p_line;
  logic tx_ready_o, rx_valid_o, enabled_o, dbg_halt_en_o, sync_busy_o;
  logic slow_req_o, irq_o, wake_o;
  logic [2:0] cfg_mode_i, mode_o;
  logic [1:0] cfg_amode_i;
  logic [3:0] flag_clr_i, pad_o, pad_oe_o;
  logic [4:0] ien_set_i, ien_clr_i, flags_o, ien_o;
  logic [7:0] addr_i, amask_i, tx_data_i, rx_data_o, p_data, p_got, pcnt;
  int errors = 0;
  int checks_done = 0;

  `define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin \
    errors++; $display("wrong value %s exp %h seen %h", nm, ex, sn); end \
  end

  // 100 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Transmit pad has a pull-up when released
  assign tx_line = pad_oe_o[0] ? pad_o[0] : 1'b1;

  // Baud 3 gives a tick every 4 cycles; rx on pad 2 keeps clear of sck
  smc_core dut (
    .ref_clk_i, .rst_i, .bus_clk_en_i, .core_clk_en_i, .ext_clk_i(1'b0),
    .cpu_halt_i, .wp_i, .dbg_we_i, .dbg_halt_en_i, .soft_reset_i,
    .cfg_we_i, .cfg_enable_i, .cfg_mode_i, .cfg_baud_i(16'h0003),
    .cfg_txpo_i(2'h0), .cfg_rxpo_i(2'h2), .cfg_amode_i, .ien_set_i,
    .ien_clr_i, .flag_clr_i, .addr_we_i, .addr_i, .amask_i, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_read_i,
    .pad_i({1'b1, p_line, 2'h3}), .pad_o, .pad_oe_o, .enabled_o, .mode_o,
    .flags_o, .ien_o, .dbg_halt_en_o, .sync_busy_o, .slow_req_o, .irq_o,
    .wake_o
  );

  smc_uart_peer #(.BIT_CYC(4)) peer (
    .ref_clk_i, .line_i(tx_line), .line_o(p_line), .send_i(p_send),
    .data_i(p_data), .got_o(p_got), .cnt_o(pcnt)
  );

  task give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One-cycle write strobes: st = {dbg_we, soft_reset, cfg_we, enable}
  task put(input logic [3:0] st, input logic [2:0] m,
    input logic [4:0] is, input logic [4:0] ic, input logic [3:0] fc);
    @(posedge ref_clk_i);
    {dbg_we_i, soft_reset_i, cfg_we_i, cfg_enable_i} <= st;
    cfg_mode_i <= m;
    ien_set_i <= is;
    ien_clr_i <= ic;
    flag_clr_i <= fc;
    @(posedge ref_clk_i);
    {dbg_we_i, soft_reset_i, cfg_we_i} <= 3'h0;
    {ien_set_i, ien_clr_i, flag_clr_i} <= 14'h0000;
    #1;
  endtask

  // Levels: {bus clock, core clock, cpu halt, write protect}
  task lvl(input logic [3:0] v);
    @(posedge ref_clk_i);
    {bus_clk_en_i, core_clk_en_i, cpu_halt_i, wp_i} <= v;
    #1;
  endtask

  // Valid held until the edge that sees ready high
  task send(input logic [7:0] b);
    int k;
    @(posedge ref_clk_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= b;
    k = 0;
    do
    begin
      @(posedge ref_clk_i);
      k++;
    end
    while (tx_ready_o !== 1'b1 && k < 300);
    tx_valid_i <= 1'b0;
    #1;
    if (k >= 300)
    begin
      errors++;
      give_verdict();
    end
  endtask

  // Peer frame takes 40 cycles; the gap lets the receiver go idle
  task psend(input logic [7:0] b);
    @(posedge ref_clk_i);
    p_send <= 1'b1;
    p_data <= b;
    @(posedge ref_clk_i);
    p_send <= 1'b0;
    repeat (44) @(posedge ref_clk_i);
  endtask

  task pop();
    @(posedge ref_clk_i);
    rx_read_i <= 1'b1;
    @(posedge ref_clk_i);
    rx_read_i <= 1'b0;
    #1;
  endtask

  // Bounded wait: sel 0 peer count equals v, else flag bits v all set
  task await(input int sel, input logic [7:0] v);
    int k;
    k = 0;
    while (k < 400 && ((sel == 0) ? pcnt : ({3'h0, flags_o} & v)) !== v)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    #1;
    if (k >= 400)
    begin
      errors++;
      give_verdict();
    end
  endtask

  // Main sequence
  initial
  begin
    {rst_i, bus_clk_en_i, core_clk_en_i, dbg_halt_en_i} = 4'hf;
    {cpu_halt_i, wp_i, dbg_we_i, soft_reset_i, cfg_we_i} = 5'h00;
    {cfg_enable_i, addr_we_i, tx_valid_i, rx_read_i, p_send} = 5'h00;
    {cfg_mode_i, cfg_amode_i} = 5'h00;
    {flag_clr_i, ien_set_i, ien_clr_i} = 14'h0000;
    {addr_i, amask_i, tx_data_i, p_data} = 32'h0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `CHK("enabled", 1'b0, enabled_o)
    `CHK("pad_oe", 4'h0, pad_oe_o)
    `CHK("tx_ready", 1'b1, tx_ready_o)
    `CHK("flags", 5'h00, flags_o)
    for (int m = 0; m < 8; m++)
    begin
      put(4'b0011, m[2:0], 5'h00, 5'h00, 4'h0);
      `CHK("mode", m[2:0], mode_o)
      `CHK("sync_busy", 1'b1, sync_busy_o)
      `CHK("slow_req", (m == 4 || m == 5), slow_req_o)
      if (m > 5) `CHK("pad_oe", 4'h0, pad_oe_o)
      put(4'b0010, 3'h1, 5'h00, 5'h00, 4'h0);
      `CHK("mode", m[2:0], mode_o)
    end
    // Back-to-back words, one waiting behind the shifter
    put(4'b0011, 3'h1, 5'h00, 5'h00, 4'h0);
    send(8'ha5);
    `CHK("tx_ready", 1'b0, tx_ready_o)
    send(8'h3c);
    repeat (20) @(posedge ref_clk_i);
    #1;
    `CHK("tx_ready", 1'b0, tx_ready_o)
    await(0, 8'h01);
    `CHK("peer word", 8'ha5, p_got)
    await(0, 8'h02);
    `CHK("peer word", 8'h3c, p_got)
    // Three words unread: two kept, overflow, no match in USART
    psend(8'h00);
    psend(8'h22);
    psend(8'h33);
    await(1, 8'h08);
    `CHK("rx_data", 8'h00, rx_data_o)
    `CHK("flags", 5'h1b, flags_o)
    pop();
    `CHK("rx_data", 8'h22, rx_data_o)
    pop();
    `CHK("rx_valid", 1'b0, rx_valid_o)
    // Interrupt enable, protection and its lifting by halt
    put(4'b0000, 3'h1, 5'h02, 5'h00, 4'h0);
    `CHK("irq", 1'b1, irq_o)
    `CHK("wake", 1'b1, wake_o)
    lvl(4'b1101);
    put(4'b0000, 3'h1, 5'h00, 5'h02, 4'h0);
    `CHK("ien", 5'h02, ien_o)
    put(4'b0010, 3'h1, 5'h00, 5'h00, 4'h0);
    `CHK("enabled", 1'b1, enabled_o)
    put(4'b0100, 3'h1, 5'h00, 5'h00, 4'h0);
    `CHK("enabled", 1'b1, enabled_o)
    put(4'b0000, 3'h1, 5'h00, 5'h00, 4'hf);
    `CHK("flags", 5'h10, flags_o)
    `CHK("irq", 1'b0, irq_o)
    lvl(4'b1111);
    put(4'b0000, 3'h1, 5'h08, 5'h00, 4'h0);
    `CHK("ien", 5'h0a, ien_o)
    // Halted cpu: runs by default, freezes once the option is set
    send(8'h55);
    await(0, 8'h03);
    `CHK("peer word", 8'h55, p_got)
    put(4'b1000, 3'h1, 5'h00, 5'h00, 4'h0);
    `CHK("dbg_halt_en", 1'b1, dbg_halt_en_o)
    send(8'h66);
    repeat (30) @(posedge ref_clk_i);
    #1;
    `CHK("tx_ready", 1'b0, tx_ready_o)
    lvl(4'b1100);
    await(0, 8'h04);
    `CHK("peer word", 8'h66, p_got)
    repeat (10) @(posedge ref_clk_i);
    put(4'b0100, 3'h1, 5'h00, 5'h00, 4'h0);
    `CHK("enabled", 1'b0, enabled_o)
    `CHK("ien", 5'h00, ien_o)
    `CHK("dbg_halt_en", 1'b1, dbg_halt_en_o)
    `CHK("sync_busy", 1'b1, sync_busy_o)
    // Bus clock off blocks writes and the data path
    lvl(4'b0100);
    `CHK("tx_ready", 1'b0, tx_ready_o)
    put(4'b0011, 3'h3, 5'h00, 5'h00, 4'h0);
    `CHK("enabled", 1'b0, enabled_o)
    // Address written under protection, then SPI master
    lvl(4'b1001);
    @(posedge ref_clk_i);
    addr_we_i <= 1'b1;
    // Two-address match: address 00 or second address 88
    amask_i <= 8'h88;
    cfg_amode_i <= 2'h1;
    @(posedge ref_clk_i);
    addr_we_i <= 1'b0;
    lvl(4'b1000);
    put(4'b0011, 3'h3, 5'h00, 5'h00, 4'h0);
    send(8'h77);
    repeat (30) @(posedge ref_clk_i);
    #1;
    `CHK("tx_ready", 1'b0, tx_ready_o)
    lvl(4'b1100);
    psend(8'h88);
    await(1, 8'h04);
    `CHK("rx_data", 8'h88, rx_data_o)
    // A word matching neither address leaves the match flag clear
    put(4'b0000, 3'h3, 5'h00, 5'h00, 4'hf);
    pop();
    psend(8'h5a);
    await(1, 8'h02);
    `CHK("flags", 5'h12, flags_o)
    `CHK("rx_data", 8'h5a, rx_data_o)
    give_verdict();
  end
endmodule
